// File: rtl/bridge_cmd_status_defs.vh
`ifndef BRIDGE_CMD_STATUS_DEFS_VH
`define BRIDGE_CMD_STATUS_DEFS_VH

// Configuration dword holding command (low half) and status (high half)
`define CMD_STAT_OFFSET        8'h04

// Command bit positions
`define CMD_IO_DECODE_BIT      0
`define CMD_MEM_DECODE_BIT     1
`define CMD_UPSTREAM_INIT_BIT  2
`define CMD_SPECIAL_CYCLE_BIT  3
`define CMD_WRITE_INVAL_BIT    4
`define CMD_VGA_SNOOP_BIT      5
`define CMD_PARITY_RESP_BIT    6
`define CMD_SYS_ERR_OUT_BIT    8

// Writable command bits and their reset value
`define CMD_WRITE_MASK         16'h0167
`define CMD_RESET              16'h0000

// Status bit positions within the dword
`define STAT_PARITY_ERR_BIT    31
`define STAT_SYS_ERR_SIG_BIT   30
`define STAT_MABORT_RX_BIT     29
`define STAT_TABORT_RX_BIT     28
`define STAT_TABORT_SIG_BIT    27
`define STAT_DEVSEL_HI         26
`define STAT_DEVSEL_LO         25
`define STAT_DATA_PAR_BIT      24
`define STAT_B2B_BIT           23
`define STAT_66MHZ_BIT         21
`define STAT_CAP_LIST_BIT      20

// Status fixed part and reset value
`define STAT_FIXED             16'h02b0
`define STAT_RESET             16'h02b0
`define STAT_EVENT_MASK        16'hf900

// VGA palette addresses (bits 9:0)
`define VGA_PAL_MASK_ADDR      10'h3c6
`define VGA_PAL_WIDX_ADDR      10'h3c8
`define VGA_PAL_DATA_ADDR      10'h3c9

`endif

// File: rtl/pci_bridge_primary_cmd_status.v
// Functional notes
// - VGA palette write: 3C6/3C8/3C9, bits 31:16 zero
// - Snoop off: palette write only inside window
// - Snoop on: claim palette writes, forward downstream
// - Write-invalidate enable reads zero, relay only
// - Special cycle enable reads zero, never respond
// - Initiator enable off: no secondary I/O or memory claim, no mastering
// - Initiator enable on: claim secondary, master upstream
// - Config forwarding ignores initiator enable
// - Memory decode enable gates primary memory claims
// - I/O decode enable gates primary I/O claims
// - Write one clears status, zero keeps
// - Bit 30 set when system error driven
// - Bit 29 set on received master abort
// - Bit 28 set on received target abort
// - Bit 27 set on signaled target abort
// - Decode timing field reads 1, medium
// - Bit 24 needs master, parity error, response enable
// - Bit 21 reads one, 66 MHz capable
// - Bits 22 and 19:16 read zero
// - Response enable off: no parity output, bit 24
// - System error output only with enable set
`include "bridge_cmd_status_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module pci_bridge_primary_cmd_status (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // Configuration access
    input  wire        cfg_wr,
    input  wire        cfg_rd,
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_be_n,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    output reg         cfg_rvalid,
    // Primary bus decode request
    input  wire        p_req,
    input  wire        p_is_io,
    input  wire        p_is_mem,
    input  wire        p_is_special,
    input  wire        p_is_write,
    input  wire [31:0] p_addr,
    input  wire        p_in_io_window,
    input  wire        p_in_mem_window,
    output reg         p_claim,
    output reg         p_vga_claim,
    // Secondary bus decode request
    input  wire        s_req,
    input  wire        s_is_io_mem,
    input  wire        s_is_cfg,
    output reg         s_claim,
    output reg         upstream_master_ok,
    // Primary bus events
    input  wire        is_primary_master,
    input  wire        addr_parity_err,
    input  wire        data_parity_err,
    input  wire        sys_err_req,
    input  wire        master_abort_rx,
    input  wire        target_abort_rx,
    input  wire        target_abort_tx,
    input  wire        relay_write_inval,
    output reg         write_inval_ok,
    // Open-drain error pins
    input  wire        primary_parity_err_n_in,
    output reg         primary_parity_err_n_out,
    output reg         primary_parity_err_n_oe,
    input  wire        primary_sys_err_n_in,
    output reg         primary_sys_err_n_out,
    output reg         primary_sys_err_n_oe,
    // Control state
    output reg  [15:0] primary_command,
    output reg  [15:0] primary_status
);

    localparam [15:0] WMASK = `CMD_WRITE_MASK;

    reg  [15:0] command_next;
    reg  [15:0] status_next;
    reg  [15:0] w1c_bits;
    reg  [15:0] set_bits;
    wire        hit;
    wire        vga_snoop_en;
    wire        parity_response_en;
    wire        sys_err_out_en;
    wire        upstream_initiator_en;
    wire        mem_decode_en;
    wire        io_decode_en;
    wire        vga_pal_wr;
    wire        perr_seen;
    wire        serr_drive;

    // Palette address test, also handy for a future snoop of reads
    function is_vga_pal;
        input [31:0] a;
        begin
            is_vga_pal = (a[31:16] == 16'h0000) &&
                         ((a[9:0] == `VGA_PAL_MASK_ADDR) ||
                          (a[9:0] == `VGA_PAL_WIDX_ADDR) ||
                          (a[9:0] == `VGA_PAL_DATA_ADDR));
        end
    endfunction

    assign hit = (cfg_addr == `CMD_STAT_OFFSET);
    assign io_decode_en          = primary_command[`CMD_IO_DECODE_BIT];
    assign mem_decode_en         = primary_command[`CMD_MEM_DECODE_BIT];
    assign upstream_initiator_en = primary_command[`CMD_UPSTREAM_INIT_BIT];
    assign vga_snoop_en          = primary_command[`CMD_VGA_SNOOP_BIT];
    assign parity_response_en    = primary_command[`CMD_PARITY_RESP_BIT];
    assign sys_err_out_en        = primary_command[`CMD_SYS_ERR_OUT_BIT];
    assign vga_pal_wr = p_is_io && p_is_write && is_vga_pal(p_addr);
    // Pin sampled directly; inputs are synchronous to the clock
    assign perr_seen  = ~primary_parity_err_n_in;
    assign serr_drive = sys_err_req && sys_err_out_en;

    // Command write: writable bits only, per byte lane
    always @* begin
        command_next = primary_command;
        if (cfg_wr && hit) begin
            if (!cfg_be_n[0]) begin
                command_next[7:0] = (cfg_wdata[7:0] & WMASK[7:0]) |
                                    (primary_command[7:0] & ~WMASK[7:0]);
            end
            if (!cfg_be_n[1]) begin
                command_next[15:8] = (cfg_wdata[15:8] & WMASK[15:8]) |
                                     (primary_command[15:8] & ~WMASK[15:8]);
            end
        end
        // Fixed zero bits regardless of write data
        command_next[`CMD_WRITE_INVAL_BIT]   = 1'b0;
        command_next[`CMD_SPECIAL_CYCLE_BIT] = 1'b0;
    end

    // Status: events set, write one clears, set beats clear
    always @* begin
        w1c_bits = 16'h0000;
        if (cfg_wr && hit) begin
            if (!cfg_be_n[2]) begin
                w1c_bits[7:0] = cfg_wdata[23:16];
            end
            if (!cfg_be_n[3]) begin
                w1c_bits[15:8] = cfg_wdata[31:24];
            end
        end
        w1c_bits = w1c_bits & `STAT_EVENT_MASK;
        set_bits = 16'h0000;
        set_bits[`STAT_PARITY_ERR_BIT - 16] =
            addr_parity_err || data_parity_err;
        set_bits[`STAT_SYS_ERR_SIG_BIT - 16] = primary_sys_err_n_oe;
        set_bits[`STAT_MABORT_RX_BIT - 16] =
            is_primary_master && master_abort_rx;
        set_bits[`STAT_TABORT_RX_BIT - 16] =
            is_primary_master && target_abort_rx;
        set_bits[`STAT_TABORT_SIG_BIT - 16] = target_abort_tx;
        set_bits[`STAT_DATA_PAR_BIT - 16] = is_primary_master &&
            (data_parity_err || perr_seen) && parity_response_en;
        status_next = ((primary_status & `STAT_EVENT_MASK & ~w1c_bits) |
                       set_bits) | `STAT_FIXED;
    end

    // Register contents
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            primary_command <= `CMD_RESET;
            primary_status  <= `STAT_RESET;
        end else begin
            primary_command <= command_next;
            primary_status  <= status_next;
        end
    end

    // Read answer one cycle after the strobe; other offsets read zero
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd && hit) begin
                cfg_rdata <= {primary_status, primary_command};
            end else if (cfg_rd) begin
                cfg_rdata <= 32'h0000_0000;
            end
        end
    end

    // Primary claim, decode enables gate each space
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            p_claim     <= 1'b0;
            p_vga_claim <= 1'b0;
        end else begin
            p_claim     <= 1'b0;
            p_vga_claim <= 1'b0;
            if (p_req && !p_is_special) begin
                if (p_is_mem && mem_decode_en && p_in_mem_window) begin
                    p_claim <= 1'b1;
                end
                if (p_is_io && io_decode_en) begin
                    if (vga_pal_wr && vga_snoop_en) begin
                        p_claim     <= 1'b1;
                        p_vga_claim <= 1'b1;
                    end else if (p_in_io_window) begin
                        p_claim <= 1'b1;
                    end
                end
            end
        end
    end

    // Secondary claim; configuration passes whatever the enable
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_claim            <= 1'b0;
            upstream_master_ok <= 1'b0;
            write_inval_ok     <= 1'b0;
        end else begin
            s_claim <= s_req && ((s_is_io_mem && upstream_initiator_en) ||
                                 s_is_cfg);
            upstream_master_ok <= upstream_initiator_en;
            // Write-invalidate only when relaying another master's cycle
            write_inval_ok <= relay_write_inval && upstream_initiator_en;
        end
    end

    // Open-drain pins: level is always low, the enable does the driving
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            primary_parity_err_n_out <= 1'b0;
            primary_parity_err_n_oe  <= 1'b0;
            primary_sys_err_n_out    <= 1'b0;
            primary_sys_err_n_oe     <= 1'b0;
        end else begin
            primary_parity_err_n_out <= 1'b0;
            primary_sys_err_n_out    <= 1'b0;
            // Parity error pin driven low only with response enabled
            primary_parity_err_n_oe <= data_parity_err &&
                                       parity_response_en;
            // Pin level not checked back; a shared line may be low anyway
            primary_sys_err_n_oe <= serr_drive;
        end
    end

endmodule

`default_nettype wire

// File: tb/cfg_host.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_host (
    // Clock
    input  wire logic        sys_clk,
    // Config access
    output var  logic        cfg_wr,
    output var  logic        cfg_rd,
    output var  logic [7:0]  cfg_addr,
    output var  logic [3:0]  cfg_be_n,
    output var  logic [31:0] cfg_wdata,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rvalid
);
    initial {cfg_wr, cfg_rd, cfg_addr, cfg_be_n, cfg_wdata} = 46'hf00000000;
    // Released lanes show inverted data, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        @(negedge sys_clk);
        {cfg_wr, cfg_addr, cfg_be_n, cfg_wdata} = {1'b1, a, b, d};
        @(negedge sys_clk);
        {cfg_wr, cfg_be_n, cfg_wdata} = {1'b0, 4'hf, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge sys_clk);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge sys_clk);
        {cfg_rd, cfg_addr} = {1'b0, ~a};
        d = cfg_rvalid ? cfg_rdata : 32'hx;
    endtask
endmodule
`default_nettype wire

// File: tb/cmd_stat_chk.sv
`timescale 1ns/100ps
`default_nettype none
module cmd_stat_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Decode
    input wire logic        p_req,
    input wire logic        p_is_io,
    input wire logic        p_is_write,
    input wire logic [31:0] p_addr,
    input wire logic        p_claim,
    input wire logic        p_vga_claim,
    input wire logic        s_req,
    input wire logic        s_is_cfg,
    input wire logic        s_claim,
    // Events and state
    input wire logic        is_primary_master,
    input wire logic        master_abort_rx,
    input wire logic        primary_sys_err_n_oe,
    input wire logic [15:0] primary_command,
    input wire logic [15:0] primary_status
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_pal;
        p_req && p_is_io && p_is_write && p_addr[31:16] == 16'h0
        && p_addr[9:0] inside {10'h3c6, 10'h3c8, 10'h3c9};
    endsequence
    sequence sys_err_signaled;
        primary_sys_err_n_oe;
    endsequence
    AST_VGA: assert property (
        s_pal ##0 (primary_command[0] && primary_command[5])
        |=> p_claim && p_vga_claim) else $error("palette not claimed");
    AST_IO_OFF: assert property (
        p_req && p_is_io && !primary_command[0] |=> !p_claim)
        else $error("io claimed while off");
    AST_CFG_FWD: assert property (s_req && s_is_cfg |=> s_claim)
        else $error("cfg not forwarded");
    AST_UP_OFF: assert property (
        s_req && !s_is_cfg && !primary_command[2] |=> !s_claim)
        else $error("secondary claimed while off");
    AST_FIXED: assert property (
        (primary_status & 16'h06ff) == 16'h02b0
        && primary_command[4:3] == 2'b00) else $error("fixed bits");
    AST_SERR_GATE: assert property (
        !$past(primary_command[8]) |-> !primary_sys_err_n_oe)
        else $error("serr driven while off");
    AST_SERR_BIT: assert property (sys_err_signaled |=> primary_status[14])
        else $error("serr not logged");
    AST_MABORT: assert property (
        master_abort_rx && is_primary_master |=> primary_status[13])
        else $error("master abort not logged");
endmodule
bind pci_bridge_primary_cmd_status cmd_stat_chk cmd_stat_chk_i (.*);
`default_nettype wire

// File: tb/pci_bridge_primary_cmd_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pci_bridge_primary_cmd_status_tb;
    logic sys_clk = 0, rst = 1, cfg_wr, cfg_rd, cfg_rvalid, p_req = 0;
    logic p_is_io, p_is_mem, p_is_special, p_is_write, p_in_io_window;
    logic p_in_mem_window, p_claim, p_vga_claim, s_req = 0, s_is_io_mem;
    logic s_is_cfg, s_claim, upstream_master_ok, is_primary_master;
    logic addr_parity_err, data_parity_err, sys_err_req, master_abort_rx;
    logic target_abort_rx, target_abort_tx, relay_write_inval = 0;
    logic write_inval_ok, primary_parity_err_n_out, primary_parity_err_n_oe;
    logic primary_sys_err_n_out, primary_sys_err_n_oe;
    logic [1:0]  sk = 0;
    logic [5:0]  pk = 0;
    logic [6:0]  ek = 0;
    logic [3:0]  cfg_be_n;
    logic [7:0]  cfg_addr;
    logic [15:0] primary_command, primary_status;
    logic [31:0] cfg_wdata, cfg_rdata, p_addr = 0, rv;
    int          errors = 0, n_tests = 0;
    // Pull-ups hold the error pins high when undriven
    wire logic   primary_parity_err_n_in =
                 primary_parity_err_n_oe ? primary_parity_err_n_out : 1'b1;
    wire logic   primary_sys_err_n_in =
                 primary_sys_err_n_oe ? primary_sys_err_n_out : 1'b1;
    assign {p_is_io, p_is_mem, p_is_special, p_is_write, p_in_io_window,
            p_in_mem_window} = pk;
    assign {s_is_cfg, s_is_io_mem} = sk;
    assign {is_primary_master, data_parity_err, addr_parity_err, sys_err_req,
            master_abort_rx, target_abort_rx, target_abort_tx} = ek;
    always #25 sys_clk = ~sys_clk;
    pci_bridge_primary_cmd_status pci_bridge_primary_cmd_status_i (.*);
    cfg_host cfg_host_i (.*);
    task automatic chk(input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        cfg_host_i.rd(a, rv);
        chk(rv, e);
    endtask
    task automatic cmd(input logic [15:0] c);
        cfg_host_i.wr(8'h04, 4'hc, {16'h0, c});
    endtask
    task automatic stop_test;
        $display("Checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_reset;
        rst = 1'b1;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        rdc(8'h04, 32'h02b0_0000);
    endtask
    task automatic t_cmd;
        cfg_host_i.wr(8'h04, 4'hc, 32'hffff_ffff);
        rdc(8'h04, 32'h02b0_0167);
        cfg_host_i.wr(8'h04, 4'he, 32'h0);
        rdc(8'h04, 32'h02b0_0100);
        cfg_host_i.wr(8'h08, 4'h0, 32'hffff_ffff);
        rdc(8'h08, 32'h0);
    endtask
    task automatic dec(input logic [5:0] k, input logic [31:0] a,
                       input logic [1:0] e);
        @(negedge sys_clk);
        {pk, p_req, p_addr} = {k, 1'b1, a};
        @(negedge sys_clk);
        {p_req, p_addr} = {1'b0, ~a};
        chk(32'({p_claim, p_vga_claim}), 32'(e));
    endtask
    task automatic t_primary;
        cmd(16'h0000);
        dec(6'h26, 32'h0000_03c8, 2'b00);
        dec(6'h15, 32'h0000_1000, 2'b00);
        cmd(16'h0023);
        dec(6'h24, 32'h0000_03c6, 2'b11);
        dec(6'h24, 32'h0000_ffc9, 2'b11);
        dec(6'h24, 32'h0001_03c8, 2'b00);
        dec(6'h24, 32'h0000_03c7, 2'b00);
        dec(6'h20, 32'h0000_03c8, 2'b00);
        dec(6'h15, 32'h0000_1000, 2'b10);
        dec(6'h08, 32'h0000_0000, 2'b00);
        cmd(16'h0003);
        dec(6'h24, 32'h0000_03c8, 2'b00);
        dec(6'h26, 32'h0000_03c8, 2'b10);
    endtask
    task automatic sec(input logic [1:0] k, input logic [2:0] e);
        @(negedge sys_clk);
        {sk, s_req, relay_write_inval} = {k, 2'b11};
        @(negedge sys_clk);
        {s_req, relay_write_inval} = 2'b00;
        chk(32'({s_claim, write_inval_ok, upstream_master_ok}), 32'(e));
    endtask
    task automatic t_secondary;
        cmd(16'h0000);
        sec(2'b01, 3'b000);
        sec(2'b10, 3'b100);
        cmd(16'h0004);
        sec(2'b01, 3'b111);
        sec(2'b10, 3'b111);
    endtask
    task automatic ev(input logic [6:0] k, input logic [15:0] c, e);
        cmd(c);
        @(negedge sys_clk);
        ek = k;
        @(negedge sys_clk);
        ek = 7'h00;
        chk(32'({primary_parity_err_n_oe, primary_sys_err_n_oe,
                 primary_parity_err_n_out, primary_sys_err_n_out}),
            32'({k[5] & c[6], k[3] & c[8], 2'b00}));
        repeat (3) @(negedge sys_clk);
        rdc(8'h04, {e, c});
        // Clear one bit only; zeros elsewhere must keep the rest
        cfg_host_i.wr(8'h04, 4'h3, 32'h2000_0000);
        rdc(8'h04, {e & 16'hdfff, c});
        cfg_host_i.wr(8'h04, 4'h3, 32'hffff_0000);
        rdc(8'h04, {16'h02b0, c});
    endtask
    task automatic t_events;
        ev(7'h7f, 16'h0144, 16'hfbb0);
        ev(7'h60, 16'h0000, 16'h82b0);
        ev(7'h0e, 16'h0000, 16'h02b0);
        ev(7'h10, 16'h0040, 16'h82b0);
    endtask
    initial begin
        t_reset;
        t_cmd;
        t_primary;
        t_secondary;
        t_events;
        cmd(16'h0167);
        t_reset;
        stop_test;
    end
    initial begin
        #500000;
        errors++;
        stop_test;
    end
endmodule
`default_nettype wire
